// *** can_transceiver_mode_control_test.sv ***
module can_transceiver_mode_control_test;
    import ctm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    logic clk = 0, rst_n = 0, we = 0, wclr = 0, txd = 1, wen = 1;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00, rdata;
    logic [2:0] cmode = 3'h7;
    ctm_sup_t sup = 5'h01;
    ctm_drv_t drv;
    ctm_trx_t st;
    logic dom, rxl, wflag, wsleep, fd;
    int n_errors = 0, checked = 0, cyc = 0;
    int n_wake_sleep = 0;
    always #2.5 clk = ~clk;
    // One-cycle pulse, so it is counted rather than looked at once
    always @(posedge clk)
    begin
        if (wsleep === 1'b1)
        begin
            n_wake_sleep++;
        end
    end
    ctm_bus_model bus (.clk(clk), .dom(dom));
    ctm_can_mode #(.SILENCE_CYC(20), .WAKE_WIN(60), .WAKE_DOM(4), .WAKE_REC(4)) dut (
        .CLK_SYS(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WE(we), .REG_RDATA(rdata), .CHIP_MODE(cmode), .BUS_WAKE_EN(wen),
        .WAKE_FLAG_CLR(wclr), .TXD_PIN(txd), .BUS_DOM_PIN(dom), .SUPPLY(sup),
        .DRIVE(drv), .TRX_STATE(st), .RXD_FORCE_LOW(rxl), .BUS_WAKE_FLAG(wflag),
        .WAKE_FROM_SLEEP(wsleep), .FD_TOL_EN(fd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        addr = a; wdata = d; we = 1; cyc_n(1); we = 0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        addr = a; cyc_n(1); chk(rdata, exp);
    endtask
    task automatic conclude();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic t_reg();
        wr(7'h20, 8'hff); rd(7'h20, 8'h73);
        chk({7'h0, fd}, 8'h01);
        rd(7'h10, 8'h00);
    endtask
    task automatic t_listen();
        wr(7'h20, 8'h03); cyc_n(1);
        chk({5'h0, st}, {5'h0, CTM_LISTEN});
        chk({3'h0, drv}, 8'h0c);
    endtask
    task automatic t_active();
        // TXD must be low through its synchroniser before the active request lands
        txd = 0;
        cyc_n(3);
        wr(7'h20, 8'h01);
        cyc_n(5);
        chk({5'h0, st}, {5'h0, CTM_LISTEN});
        txd = 1;
        cyc_n(5);
        chk({5'h0, st}, {5'h0, CTM_ACTIVE});
        // Regulator reset: two sync edges, then one state edge
        sup = 5'h09;
        cyc_n(3);
        chk({5'h0, st}, {5'h0, CTM_OFFLINE});
        chk({3'h0, drv}, 8'h02);
        sup = 5'h01;
        cmode = 3'h4;
        cyc_n(2);
    endtask
    task automatic t_bias();
        bus.phase(1'b1, 2); bus.phase(1'b0, 1); cyc_n(4);
        chk({5'h0, st}, {5'h0, CTM_OFFBIAS});
        cyc_n(30);
        chk({5'h0, st}, {5'h0, CTM_OFFLINE});
    endtask
    task automatic t_wake();
        cmode = 3'h1;
        bus.wake_pattern();
        cyc_n(3);
        chk({7'h0, wflag}, 8'h01);
        chk({7'h0, rxl}, 8'h01);
        chk(n_wake_sleep[7:0], 8'h01);
        chk({5'h0, st}, {5'h0, CTM_OFFBIAS});
        wclr = 1;
        cyc_n(1);
        wclr = 0;
        chk({7'h0, wflag}, 8'h00);
    endtask
    task automatic t_off();
        sup = 5'h03; cyc_n(5);
        chk({3'h0, drv}, 8'h01);
        sup = 5'h01; cyc_n(5);
        chk({5'h0, st}, {5'h0, CTM_OFFLINE});
        cmode = 3'h0; cyc_n(2); cmode = 3'h2; cyc_n(2);
        chk({5'h0, st}, {5'h0, CTM_OFFLINE});
    endtask
    initial
    begin
        cyc_n(16);
        rst_n = 1;
        cyc_n(4);
        t_reg();
        t_listen();
        t_active();
        t_bias();
        t_wake();
        t_off();
        conclude();
    end
endmodule

// *** ctm_bus_model.sv ***
module ctm_bus_model
    import ctm_pkg::*;
(
    input  wire logic clk, // System clock
    output logic      dom  // Bus level, 1 = dominant
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Remote node on the bus
    // ****************************************
    initial dom = 1'b0;
    // Recessive is the terminated idle level
    task automatic phase(input logic lvl, input int n);
        @(posedge clk);
        #1 dom = lvl;
        repeat (n - 1) @(posedge clk);
    endtask
    task automatic wake_pattern();
        phase(1'b1, 6);
        phase(1'b0, 2);
        phase(1'b1, 1);
        phase(1'b0, 6);
        phase(1'b1, 6);
        phase(1'b0, 1);
    endtask
endmodule

// *** ctm_can_mode.sv ***
module ctm_can_mode
    import ctm_pkg::*;
#(
    parameter int SILENCE_CYC = CTM_SILENCE_CYC,
    parameter int WAKE_WIN    = CTM_WAKE_WIN_CYC,
    parameter int WAKE_DOM    = CTM_WAKE_DOM_CYC,
    parameter int WAKE_REC    = CTM_WAKE_REC_CYC
)(
    input  wire logic       CLK_SYS,        // 200 MHz system clock
    input  wire logic       RESET_N,        // Async reset, active low
    input  wire logic [6:0] REG_ADDR,       // Register address
    input  wire logic [7:0] REG_WDATA,      // Register write data
    input  wire logic       REG_WE,         // Register write strobe
    output logic      [7:0] REG_RDATA,      // Registered read data
    input  wire logic [2:0] CHIP_MODE,      // Chip mode select
    input  wire logic       BUS_WAKE_EN,    // Bus wake enable
    input  wire logic       WAKE_FLAG_CLR,  // Clear bus wake flag
    input  wire logic       TXD_PIN,        // Transmit data pin
    input  wire logic       BUS_DOM_PIN,    // Bus receiver, 1 = dominant
    input  wire ctm_sup_t   SUPPLY,         // Supply comparator flags
    output ctm_drv_t        DRIVE,          // Analog front-end controls
    output ctm_trx_t        TRX_STATE,      // Transceiver state
    output logic            RXD_FORCE_LOW,  // Hold receive output low
    output logic            BUS_WAKE_FLAG,  // Sticky bus wake event
    output logic            WAKE_FROM_SLEEP,// Regulator on, go standby
    output logic            FD_TOL_EN       // FD tolerance enable
);

    // ************************************************
    // Declarations
    // ************************************************
    localparam int SW = $clog2(SILENCE_CYC + 1);
    localparam logic [SW-1:0] SIL_C = SW'(SILENCE_CYC);

    logic [6:0]    sync1_r;
    logic [6:0]    sync2_r;
    logic          txd_s;
    logic          bus_s;
    ctm_sup_t      sup_s;
    logic          bus_q_r;
    logic          bus_edge;
    logic [SW-1:0] sil_r;
    logic [SW-1:0] sil_nxt;
    logic          silent;
    logic [2:0]    prev_mc_r;
    ctm_ctrl_t     ctrl_r;
    ctm_ctrl_t     ctrl_nxt;
    ctm_trx_t      state_r;
    ctm_trx_t      state_nxt;
    ctm_drv_t      drv_nxt;
    logic [1:0]    sel;
    logic          normal;
    logic          chip_off;
    logic          off_cond;
    logic          off_to_rst;
    logic          want_act;
    logic          want_lis;
    logic          want_off;
    logic          act_ok;
    logic          act_drop;
    logic          transceiver_supply_blk;
    logic          sel_enter;
    ctm_trx_t      sel_state;
    ctm_trx_t      quiet_state;
    logic          wk_en;
    logic          wake_hit;
    logic          ctrl_wr;
    logic [7:0]    stat_rd;
    logic [7:0]    rd_mux;
    logic          rxd_low_nxt;
    logic          flag_nxt;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sync1_r <= CTM_SYNC_RST;
            sync2_r <= CTM_SYNC_RST;
        end
        else
        begin
            sync1_r <= {TXD_PIN, BUS_DOM_PIN, SUPPLY};
            sync2_r <= sync1_r;
        end
    end

    assign txd_s = sync2_r[6];
    assign bus_s = sync2_r[5];
    assign sup_s = ctm_sup_t'(sync2_r[4:0]);

    // ************************************************
    // Bus silence timer
    // ************************************************
    assign bus_edge = bus_s != bus_q_r;
    assign sil_nxt  = bus_edge ? '0 : (silent ? sil_r : sil_r + SW'(1));
    assign silent   = sil_r >= SIL_C;

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            bus_q_r   <= 1'b0;
            sil_r     <= '0;
            prev_mc_r <= CTM_MC_OFF;
        end
        else
        begin
            bus_q_r   <= bus_s;
            sil_r     <= sil_nxt;
            prev_mc_r <= CHIP_MODE;
        end
    end

    // ************************************************
    // Control register and read port
    // ************************************************
    assign ctrl_wr  = REG_WE && (REG_ADDR == CTM_CTRL_ADDR);
    assign ctrl_nxt = ctrl_wr ? ctm_ctrl_t'(REG_WDATA & CTM_CTRL_WMASK)
                              : ctrl_r;
    assign stat_rd  = (8'((state_r == CTM_ACTIVE)) << CTM_CTS_BIT)
                    | (8'(silent) << CTM_CBSS_BIT)
                    | (8'((sel == CTM_SEL_ACT_UV) && sup_s.transceiver_supply_uv) << CTM_VCS_BIT);
    assign rd_mux   = (REG_ADDR == CTM_CTRL_ADDR) ? 8'(ctrl_r)
                    : ((REG_ADDR == CTM_STAT_ADDR) ? stat_rd : 8'h00);

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ctrl_r    <= ctm_ctrl_t'(CTM_CTRL_RST);
            REG_RDATA <= 8'h00;
            FD_TOL_EN <= 1'b0;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            REG_RDATA <= rd_mux;
            FD_TOL_EN <= ctrl_nxt.fd_tolerance_enable;
        end
    end

    // ************************************************
    // Mode request decode
    // ************************************************
    assign sel      = ctrl_r.transceiver_mode_select;
    assign normal   = CHIP_MODE == CTM_MC_NORMAL;
    assign chip_off = (CHIP_MODE == CTM_MC_OFF) || (CHIP_MODE == CTM_MC_OVERTEMP);
    assign off_cond = chip_off || sup_s.vbat_uv;
    assign off_to_rst = ((prev_mc_r == CTM_MC_OFF) || (prev_mc_r == CTM_MC_OVERTEMP))
                      && (CHIP_MODE == CTM_MC_RESET);
    assign want_act = normal && ((sel == CTM_SEL_ACT_UV) || (sel == CTM_SEL_ACT));
    assign want_lis = normal && (sel == CTM_SEL_LISTEN);
    assign want_off = !normal || (sel == CTM_SEL_OFFLINE);
    // Select 10 ignores the 90 % check and only stops at regulator reset
    assign act_ok   = txd_s && !sup_s.v1_rst
                    && !((sel == CTM_SEL_ACT_UV) && sup_s.v1_uv90);
    assign act_drop = sup_s.v1_rst
                    || ((sel == CTM_SEL_ACT_UV) && (sup_s.transceiver_supply_uv || sup_s.v1_uv90));
    assign transceiver_supply_blk = want_act && sup_s.transceiver_supply_uv;
    assign sel_enter = want_lis || (want_act && !transceiver_supply_blk);
    assign sel_state = (want_act && act_ok) ? CTM_ACTIVE : CTM_LISTEN;
    assign quiet_state = silent ? CTM_OFFLINE : CTM_OFFBIAS;

    // ************************************************
    // Transceiver state machine
    // ************************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CTM_TRX_OFF:
            begin
                if (!chip_off && !sup_s.vbat_uv && sup_s.vbat_ok)
                begin
                    state_nxt = CTM_OFFLINE;
                end
            end
            CTM_OFFLINE:
            begin
                if (sel_enter)
                begin
                    state_nxt = sel_state;
                end
                else if (wake_hit || bus_edge || transceiver_supply_blk)
                begin
                    state_nxt = CTM_OFFBIAS;
                end
            end
            CTM_OFFBIAS:
            begin
                if (sel_enter)
                begin
                    state_nxt = sel_state;
                end
                else if (silent)
                begin
                    state_nxt = CTM_OFFLINE;
                end
            end
            CTM_ACTIVE:
            begin
                if (want_off || act_drop)
                begin
                    state_nxt = quiet_state;
                end
                else if (want_lis)
                begin
                    state_nxt = CTM_LISTEN;
                end
            end
            CTM_LISTEN:
            begin
                if (want_off)
                begin
                    state_nxt = quiet_state;
                end
                else if (want_act && act_ok)
                begin
                    state_nxt = CTM_ACTIVE;
                end
            end
            default: state_nxt = CTM_TRX_OFF;
        endcase
        if (off_to_rst)
        begin
            state_nxt = CTM_OFFLINE;
        end
        if (off_cond)
        begin
            state_nxt = CTM_TRX_OFF;
        end
    end

    // Front-end controls follow the next state, so they line up with TRX_STATE
    assign drv_nxt.tx_en     = state_nxt == CTM_ACTIVE;
    assign drv_nxt.rx_en     = (state_nxt == CTM_ACTIVE) || (state_nxt == CTM_LISTEN);
    assign drv_nxt.bias_2v5  = drv_nxt.rx_en || (state_nxt == CTM_OFFBIAS);
    assign drv_nxt.bias_gnd  = state_nxt == CTM_OFFLINE;
    assign drv_nxt.bus_float = state_nxt == CTM_TRX_OFF;

    // ************************************************
    // Standard wake-up detection
    // ************************************************
    // Offline-bias differs from offline only in bias level; watching must go on
    // there, else the first dominant edge of a pattern would disarm the filter
    assign wk_en = ((state_r == CTM_OFFLINE) || (state_r == CTM_OFFBIAS)) && BUS_WAKE_EN
                 && (!ctrl_r.selective_wake_enable
                     || !ctrl_r.selective_config_valid);

    // Phase minimums and window are checked inside
    ctm_wake_det #(
        .DOM_MIN (WAKE_DOM),
        .REC_MIN (WAKE_REC),
        .WINDOW  (WAKE_WIN)
    ) u_wake (
        .clk   (CLK_SYS),
        .rst_n (RESET_N),
        .en    (wk_en),
        .dom   (bus_s),
        .hit   (wake_hit)
    );

    // Set wins over a clear in the same cycle
    assign flag_nxt    = wake_hit || (BUS_WAKE_FLAG && !WAKE_FLAG_CLR);
    assign rxd_low_nxt = wake_hit || (RXD_FORCE_LOW && !drv_nxt.rx_en);

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_r         <= CTM_TRX_OFF;
            DRIVE           <= '0;
            BUS_WAKE_FLAG   <= 1'b0;
            RXD_FORCE_LOW   <= 1'b0;
            WAKE_FROM_SLEEP <= 1'b0;
        end
        else
        begin
            state_r         <= state_nxt;
            DRIVE           <= drv_nxt;
            BUS_WAKE_FLAG   <= flag_nxt;
            RXD_FORCE_LOW   <= rxd_low_nxt;
            WAKE_FROM_SLEEP <= wake_hit && (CHIP_MODE == CTM_MC_SLEEP);
        end
    end

    assign TRX_STATE = state_r;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    listen_drive_a: assert property (
        state_r == CTM_LISTEN |-> !DRIVE.tx_en && DRIVE.rx_en && DRIVE.bias_2v5)
        else $error("listen-only drive wrong");

    listen_entry_a: assert property (
        state_r == CTM_OFFLINE && want_lis && !off_cond && !off_to_rst
        |=> state_r == CTM_LISTEN)
        else $error("listen-only not entered");

    txd_hold_a: assert property (
        state_r == CTM_LISTEN && !txd_s && !want_off && !off_cond && !off_to_rst
        |=> state_r == CTM_LISTEN && !DRIVE.tx_en)
        else $error("left listen-only with TXD low");

    offline_bias_a: assert property (
        state_r == CTM_OFFLINE |-> DRIVE.bias_gnd && !DRIVE.bias_2v5)
        else $error("offline bias wrong");

    activity_bias_a: assert property (
        state_r == CTM_OFFLINE && bus_edge && !sel_enter && !off_cond && !off_to_rst
        |=> state_r == CTM_OFFBIAS)
        else $error("activity did not bias bus");

    silence_exit_a: assert property (
        state_r == CTM_OFFBIAS && silent && !sel_enter && !off_cond && !off_to_rst
        |=> state_r == CTM_OFFLINE && DRIVE.bias_gnd)
        else $error("silence did not return offline");

    quiet_req_a: assert property (
        (state_r == CTM_ACTIVE || state_r == CTM_LISTEN) && want_off
        && !off_cond && !off_to_rst
        |=> state_r == ($past(silent) ? CTM_OFFLINE : CTM_OFFBIAS))
        else $error("offline request path wrong");

    uv_drop_a: assert property (
        state_r == CTM_ACTIVE && act_drop && !off_cond && !off_to_rst
        |=> state_r inside {CTM_OFFLINE, CTM_OFFBIAS} && !DRIVE.tx_en)
        else $error("active kept under undervoltage");

    off_entry_a: assert property (
        off_cond |=> state_r == CTM_TRX_OFF && DRIVE.bus_float)
        else $error("transceiver not switched off");

    wake_gate_a: assert property (
        wake_hit |-> $past(wk_en))
        else $error("wake seen while not armed");

    wake_flag_a: assert property (
        wake_hit |=> BUS_WAKE_FLAG && RXD_FORCE_LOW)
        else $error("wake flag or receive low missing");

    sleep_wake_a: assert property (
        wake_hit && CHIP_MODE == CTM_MC_SLEEP |=> WAKE_FROM_SLEEP)
        else $error("sleep wake request missing");

    ctrl_write_a: assert property (
        ctrl_wr |=> 8'(ctrl_r) == ($past(REG_WDATA) & CTM_CTRL_WMASK) ##1 FD_TOL_EN
        == ctrl_r.fd_tolerance_enable)
        else $error("control write not stored");

endmodule

// *** ctm_pkg.sv ***
package ctm_pkg;

    // ************************************************
    // Register map and fields
    // ************************************************
    localparam logic [6:0] CTM_CTRL_ADDR  = 7'h20;
    localparam logic [6:0] CTM_STAT_ADDR  = 7'h22;
    localparam logic [7:0] CTM_CTRL_RST   = 8'h00;
    localparam logic [7:0] CTM_CTRL_WMASK = 8'h73;
    localparam int         CTM_CTS_BIT    = 7;
    localparam int         CTM_CBSS_BIT   = 3;
    localparam int         CTM_VCS_BIT    = 1;

    // ************************************************
    // Mode select and chip mode codes
    // ************************************************
    localparam logic [1:0] CTM_SEL_OFFLINE = 2'h0;
    localparam logic [1:0] CTM_SEL_ACT_UV  = 2'h1;
    localparam logic [1:0] CTM_SEL_ACT     = 2'h2;
    localparam logic [1:0] CTM_SEL_LISTEN  = 2'h3;
    localparam logic [2:0] CTM_MC_NORMAL   = 3'h7;
    localparam logic [2:0] CTM_MC_OFF      = 3'h0;
    localparam logic [2:0] CTM_MC_SLEEP    = 3'h1;
    localparam logic [2:0] CTM_MC_RESET    = 3'h2;
    localparam logic [2:0] CTM_MC_OVERTEMP = 3'h3;
    localparam logic [2:0] CTM_MC_STANDBY  = 3'h4;

    // ************************************************
    // Timing counts in CLK_SYS cycles and synchroniser reset value
    // ************************************************
    localparam int         CTM_SILENCE_CYC  = 200000;
    localparam int         CTM_WAKE_WIN_CYC = 200000;
    localparam int         CTM_WAKE_DOM_CYC = 100;
    localparam int         CTM_WAKE_REC_CYC = 100;
    localparam logic [6:0] CTM_SYNC_RST     = 7'h40;

    // ************************************************
    // Types
    // ************************************************
    typedef struct packed {
        logic v1_uv90;
        logic v1_rst;
        logic transceiver_supply_uv;
        logic vbat_uv;
        logic vbat_ok;
    } ctm_sup_t;

    typedef struct packed {
        logic       rsv7;
        logic       fd_tolerance_enable;
        logic       selective_config_valid;
        logic       selective_wake_enable;
        logic [1:0] rsv;
        logic [1:0] transceiver_mode_select;
    } ctm_ctrl_t;

    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic bias_2v5;
        logic bias_gnd;
        logic bus_float;
    } ctm_drv_t;

    typedef enum logic [2:0] {
        CTM_TRX_OFF, CTM_OFFLINE, CTM_OFFBIAS, CTM_ACTIVE, CTM_LISTEN
    } ctm_trx_t;

    typedef enum logic [1:0] {WK_IDLE, WK_REC, WK_DOM2} ctm_wk_t;

endpackage

// *** ctm_wake_det.sv ***
module ctm_wake_det
    import ctm_pkg::*;
#(
    parameter int DOM_MIN = CTM_WAKE_DOM_CYC,
    parameter int REC_MIN = CTM_WAKE_REC_CYC,
    parameter int WINDOW  = CTM_WAKE_WIN_CYC
)(
    input  wire logic clk,   // System clock
    input  wire logic rst_n, // Async reset, active low
    input  wire logic en,    // Monitoring allowed
    input  wire logic dom,   // Synchronised bus level, 1 = dominant
    output logic      hit    // One-cycle wake pulse
);

    localparam int RW = $clog2((DOM_MIN > REC_MIN ? DOM_MIN : REC_MIN) + 1);
    localparam int WW = $clog2(WINDOW + 1);
    localparam logic [RW-1:0] DOM_C = RW'(DOM_MIN);
    localparam logic [RW-1:0] REC_C = RW'(REC_MIN);
    localparam logic [RW-1:0] RUN_MAX = {RW{1'b1}};
    localparam logic [WW-1:0] WIN_C = WW'(WINDOW);

    logic          dom_q_r;
    logic [RW-1:0] run_r;
    logic [RW-1:0] run_nxt;
    logic [WW-1:0] win_r;
    logic [WW-1:0] win_nxt;
    ctm_wk_t       st_r;
    ctm_wk_t       st_nxt;
    logic          dom_ok;
    logic          rec_ok;
    logic          timeout;
    logic          hit_nxt;

    // ************************************************
    // Phase length and window
    // ************************************************
    assign run_nxt = (dom != dom_q_r) ? RW'(1)
                   : ((run_r == RUN_MAX) ? run_r : run_r + RW'(1));
    assign dom_ok  = dom && (run_nxt >= DOM_C);
    assign rec_ok  = !dom && (run_nxt >= REC_C);
    assign timeout = win_r >= WIN_C;
    assign win_nxt = (st_r == WK_IDLE) ? '0 : win_r + WW'(1);
    assign hit_nxt = en && (st_r == WK_DOM2) && dom_ok && !timeout;

    // Short blips between phases do not reset progress
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            WK_IDLE: if (dom_ok) st_nxt = WK_REC;
            WK_REC:  if (rec_ok) st_nxt = WK_DOM2;
            WK_DOM2: if (dom_ok) st_nxt = WK_IDLE;
            default: st_nxt = WK_IDLE;
        endcase
        if (!en || timeout)
        begin
            st_nxt = WK_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dom_q_r <= 1'b0;
            run_r   <= '0;
            win_r   <= '0;
            st_r    <= WK_IDLE;
            hit     <= 1'b0;
        end
        else
        begin
            dom_q_r <= dom;
            run_r   <= run_nxt;
            win_r   <= win_nxt;
            st_r    <= st_nxt;
            hit     <= hit_nxt;
        end
    end

endmodule
